// *** lcdsd_defines.svh ***
// constants of the segment lcd driver: offsets, field values, counts
`ifndef LCDSD_DEFINES_SVH
`define LCDSD_DEFINES_SVH
`define LCDSD_BANK_SEL_ADDR 8'h04
`define LCDSD_BANK_SEL_RESET 8'h00
`define LCDSD_DISP_FIRST 8'h40
`define LCDSD_DISP_LAST 8'h60
`define LCDSD_DISP_BANK 8'h01
`define LCDSD_SEG_COUNT 33
`define LCDSD_COM_COUNT 4
`define LCDSD_SYS_PRE_DIV 2'h3
`define LCDSD_DIV_MIN_EXP 2
`define LCDSD_DIV_SEL_MAX 3'h6
`define LCDSD_LOW_GROUP_TOP 7
`define LCDSD_MID_GROUP_TOP 15
`define LCDSD_LVL_VSS 2'h0
`define LCDSD_LVL_LOW 2'h1
`define LCDSD_LVL_HIGH 2'h2
`define LCDSD_LVL_VLCD 2'h3
`endif

// *** lcdsd_pkg.sv ***
// types shared by the segment lcd driver
package lcdsd_pkg;
	typedef enum logic [1:0] {
		LCDSD_DUTY_HALF,
		LCDSD_DUTY_THIRD,
		LCDSD_DUTY_QUARTER,
		LCDSD_DUTY_RSVD
	} lcdsd_duty_t;
	typedef enum logic [1:0] {
		LCDSD_SRC_SYS_DIV4,
		LCDSD_SRC_RTC,
		LCDSD_SRC_WDT,
		LCDSD_SRC_RSVD
	} lcdsd_src_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic indirect;
	} lcdsd_cpu_req_t;
	typedef struct packed {
		lcdsd_duty_t duty;
		logic third_bias;
		lcdsd_src_t src;
		logic [2:0] div_sel;
		logic on_in_halt;
		logic low_group_logic;
		logic [7:0] middle_group_logic;
	} lcdsd_option_t;
endpackage

// *** lcdsd_driver.sv ***
// segment lcd driver: display memory window, bank select, scan and drive
`include "lcdsd_defines.svh"

module lcdsd_driver
	import lcdsd_pkg::*;
#(
	parameter int SEGS = `LCDSD_SEG_COUNT,
	parameter int COMS = `LCDSD_COM_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// processor data memory access
	input wire lcdsd_cpu_req_t cpu_req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output lcdsd_cpu_req_t gp_req,
	output logic [7:0] bank_select_pointer,
	// options and core state
	input wire lcdsd_option_t opt,
	input wire logic halt,
	// oscillator pins
	input wire logic real_time_oscillator,
	input wire logic watchdog_oscillator,
	// panel drive level codes
	output logic [COMS-1:0][1:0] com_level,
	output logic [SEGS-1:0][1:0] seg_level
);
	localparam int DEPTH = 32'(`LCDSD_DISP_LAST) - 32'(`LCDSD_DISP_FIRST) + 1;

	// cpu side state
	logic [7:0] disp_mem [DEPTH];
	logic [7:0] bank_reg, bank_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	lcdsd_cpu_req_t gp_req_reg, gp_req_next;
	logic disp_hit, disp_we;
	logic [5:0] disp_idx;

	always_comb begin
		disp_idx = 6'(cpu_req.addr - `LCDSD_DISP_FIRST);
		// only the indirect path with bank one sees the display window
		disp_hit = cpu_req.indirect && bank_reg == `LCDSD_DISP_BANK
			&& cpu_req.addr >= `LCDSD_DISP_FIRST
			&& cpu_req.addr <= `LCDSD_DISP_LAST;
		disp_we = disp_hit && cpu_req.wr;
		bank_next = bank_reg;
		if (cpu_req.wr && cpu_req.addr == `LCDSD_BANK_SEL_ADDR) begin
			bank_next = cpu_req.wdata;
		end
		rd_valid_next = cpu_req.rd
			&& (disp_hit || cpu_req.addr == `LCDSD_BANK_SEL_ADDR);
		rd_data_next = 8'h00;
		if (cpu_req.rd && disp_hit) begin
			rd_data_next = disp_mem[disp_idx];
		end else if (cpu_req.rd && cpu_req.addr == `LCDSD_BANK_SEL_ADDR) begin
			rd_data_next = bank_reg;
		end
		// everything but the window and the bank select register goes on to general RAM
		gp_req_next = cpu_req;
		if (disp_hit || cpu_req.addr == `LCDSD_BANK_SEL_ADDR) begin
			gp_req_next.wr = 1'b0;
			gp_req_next.rd = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bank_reg <= `LCDSD_BANK_SEL_RESET;
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
			gp_req_reg <= '0;
		end else begin
			bank_reg <= bank_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			gp_req_reg <= gp_req_next;
		end
	end

	// display memory has no reset; software fills it before enabling glass
	always_ff @(posedge clk) begin
		if (disp_we) begin
			disp_mem[disp_idx] <= cpu_req.wdata;
		end
	end

	// clock source and scan divider
	logic [1:0] rtc_sync_reg, rtc_sync_next;
	logic [1:0] wdt_sync_reg, wdt_sync_next;
	logic rtc_last_reg, rtc_last_next;
	logic wdt_last_reg, wdt_last_next;
	logic [1:0] pre_reg, pre_next;
	logic [7:0] div_reg, div_next;
	logic src_tick, scan_tick;
	logic [7:0] div_top;
	logic [2:0] div_sel;

	always_comb begin
		rtc_sync_next = {rtc_sync_reg[0], real_time_oscillator};
		wdt_sync_next = {wdt_sync_reg[0], watchdog_oscillator};
		rtc_last_next = rtc_sync_reg[1];
		wdt_last_next = wdt_sync_reg[1];
		pre_next = 2'(pre_reg + 2'h1);
		case (opt.src)
			LCDSD_SRC_SYS_DIV4: src_tick = pre_reg == `LCDSD_SYS_PRE_DIV;
			LCDSD_SRC_RTC: src_tick = rtc_sync_reg[1] && !rtc_last_reg;
			LCDSD_SRC_WDT: src_tick = wdt_sync_reg[1] && !wdt_last_reg;
			default: src_tick = 1'b0;
		endcase
		div_sel = opt.div_sel > `LCDSD_DIV_SEL_MAX ? `LCDSD_DIV_SEL_MAX
			: opt.div_sel;
		div_top = 8'((9'h001 << (32'(div_sel) + `LCDSD_DIV_MIN_EXP)) - 9'h001);
		scan_tick = src_tick && div_reg >= div_top;
		div_next = div_reg;
		if (src_tick) begin
			div_next = scan_tick ? 8'h00 : 8'(div_reg + 8'h01);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rtc_sync_reg <= 2'h0;
			wdt_sync_reg <= 2'h0;
			rtc_last_reg <= 1'b0;
			wdt_last_reg <= 1'b0;
			pre_reg <= 2'h0;
			div_reg <= 8'h00;
		end else begin
			rtc_sync_reg <= rtc_sync_next;
			wdt_sync_reg <= wdt_sync_next;
			rtc_last_reg <= rtc_last_next;
			wdt_last_reg <= wdt_last_next;
			pre_reg <= pre_next;
			div_reg <= div_next;
		end
	end

	// common scan: slot per common, polarity flips after each full frame
	logic [1:0] slot_reg, slot_next;
	logic invert_reg, invert_next;
	logic [1:0] last_slot;

	always_comb begin
		case (opt.duty)
			LCDSD_DUTY_HALF: last_slot = 2'h1;
			LCDSD_DUTY_THIRD: last_slot = 2'h2;
			LCDSD_DUTY_QUARTER: last_slot = 2'h3;
			default: last_slot = 2'h2;
		endcase
		slot_next = slot_reg;
		invert_next = invert_reg;
		if (slot_reg > last_slot) begin
			slot_next = 2'h0;
		end else if (scan_tick) begin
			slot_next = slot_reg == last_slot ? 2'h0 : 2'(slot_reg + 2'h1);
			invert_next = slot_reg == last_slot ? !invert_reg : invert_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			slot_reg <= 2'h0;
			invert_reg <= 1'b0;
		end else begin
			slot_reg <= slot_next;
			invert_reg <= invert_next;
		end
	end

	// level codes: with half bias the two middle codes stand for one level
	function automatic logic [1:0] lvl(input logic sel, input logic inv,
		input logic third);
		logic [1:0] mid;
		mid = third ? (inv ? `LCDSD_LVL_HIGH : `LCDSD_LVL_LOW)
			: `LCDSD_LVL_LOW;
		lvl = sel ? (inv ? `LCDSD_LVL_VSS : `LCDSD_LVL_VLCD) : mid;
	endfunction

	logic [COMS-1:0][1:0] com_next;
	logic [SEGS-1:0][1:0] seg_next;
	logic [COMS-1:0][1:0] com_level_reg;
	logic [SEGS-1:0][1:0] seg_level_reg;
	logic blank;

	always_comb begin
		blank = halt && !opt.on_in_halt;
		for (int c = 0; c < COMS; c++) begin
			if (blank || 2'(c) > last_slot) begin
				com_next[c] = `LCDSD_LVL_VSS;
			end else begin
				com_next[c] = lvl(slot_reg == 2'(c), invert_reg,
					opt.third_bias);
			end
		end
	end

	genvar s;
	generate
		for (s = 0; s < SEGS; s++) begin : g_seg
			logic on_bit, as_logic;
			logic [1:0] off_lvl;
			assign on_bit = disp_mem[s][slot_reg];
			// off pixel: 1/3 bias uses the far middle, 1/2 bias follows com
			assign off_lvl = opt.third_bias
				? (invert_reg ? `LCDSD_LVL_LOW : `LCDSD_LVL_HIGH)
				: (invert_reg ? `LCDSD_LVL_VSS : `LCDSD_LVL_VLCD);
			if (s <= `LCDSD_LOW_GROUP_TOP) begin : g_low
				assign as_logic = opt.low_group_logic;
			end else if (s <= `LCDSD_MID_GROUP_TOP) begin : g_mid
				assign as_logic = opt.middle_group_logic[s - 8];
			end else begin : g_lcd
				assign as_logic = 1'b0;
			end
			always_comb begin
				if (as_logic) begin
					seg_next[s] = disp_mem[s][0] ? `LCDSD_LVL_VLCD
						: `LCDSD_LVL_VSS;
				end else if (blank) begin
					seg_next[s] = `LCDSD_LVL_VSS;
				end else if (s == SEGS - 1 && opt.duty == LCDSD_DUTY_QUARTER) begin
					seg_next[s] = com_next[COMS-1];
				end else if (on_bit) begin
					seg_next[s] = invert_reg ? `LCDSD_LVL_VLCD
						: `LCDSD_LVL_VSS;
				end else begin
					seg_next[s] = off_lvl;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset) begin
			com_level_reg <= '0;
			seg_level_reg <= '0;
		end else begin
			com_level_reg <= com_next;
			seg_level_reg <= seg_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign gp_req = gp_req_reg;
	assign bank_select_pointer = bank_reg;
	assign com_level = com_level_reg;
	assign seg_level = seg_level_reg;
endmodule // lcdsd_driver

// *** lcdsd_driver_props.sv ***
// assertions on the ports of the segment lcd driver
module lcdsd_driver_props
	import lcdsd_pkg::*;
#(
	parameter int SEGS = 33,
	parameter int COMS = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// access side
	input wire lcdsd_cpu_req_t cpu_req,
	input wire logic rd_valid,
	input wire lcdsd_cpu_req_t gp_req,
	input wire logic [7:0] bank_select_pointer,
	// options and drive codes
	input wire lcdsd_option_t opt,
	input wire logic halt,
	input wire logic [COMS-1:0][1:0] com_level,
	input wire logic [SEGS-1:0][1:0] seg_level
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic hit;
	logic bank_one;
	assign bank_one = bank_select_pointer == 8'h01;
	assign hit = cpu_req.rd && cpu_req.indirect && bank_one &&
		cpu_req.addr inside {[8'h40:8'h60]};
	bank_write_a: assert property (cpu_req.wr && cpu_req.addr == 8'h04 |=>
		bank_select_pointer == $past(cpu_req.wdata) && !gp_req.wr)
		else $error("bank write lost");
	disp_read_a: assert property (hit |=> rd_valid && !gp_req.rd)
		else $error("window read not claimed");
	bank_zero_a: assert property (cpu_req.rd && !bank_one &&
		cpu_req.addr != 8'h04 |=> !rd_valid && gp_req.rd)
		else $error("bank zero read claimed");
	direct_only_a: assert property (cpu_req.rd && !cpu_req.indirect &&
		cpu_req.addr != 8'h04 |=> gp_req.rd && !rd_valid)
		else $error("direct read claimed");
	half_duty_a: assert property (opt.duty == LCDSD_DUTY_HALF |=>
		com_level[2] == 2'h0 && com_level[3] == 2'h0)
		else $error("third common driven in half duty");
	third_duty_a: assert property (opt.duty == LCDSD_DUTY_THIRD |=>
		com_level[3] == 2'h0) else $error("fourth common driven");
	quarter_com_a: assert property (opt.duty == LCDSD_DUTY_QUARTER |=>
		seg_level[32] == com_level[3]) else $error("last segment not common");
	halt_blank_a: assert property (halt && !opt.on_in_halt |=>
		com_level == '0) else $error("commons driven in halt");
	logic_out_a: assert property (opt.low_group_logic |=>
		seg_level[0] inside {2'h0, 2'h3}) else $error("logic level wrong");
	cover property (hit);
	cover property (opt.duty == LCDSD_DUTY_QUARTER && com_level[3] == 2'h3);
	cover property (halt && !opt.on_in_halt);
endmodule // lcdsd_driver_props

bind lcdsd_driver lcdsd_driver_props #(.SEGS(SEGS), .COMS(COMS)) i_props (
	.clk(clk), .reset(reset), .cpu_req(cpu_req), .rd_valid(rd_valid),
	.gp_req(gp_req), .bank_select_pointer(bank_select_pointer), .opt(opt),
	.halt(halt), .com_level(com_level), .seg_level(seg_level));

// *** lcdsd_panel.sv ***
// passive glass model: records every pixel that has seen full drive
module lcdsd_panel (
	// clock
	input wire logic clk,
	// drive codes from the driver
	input wire logic [3:0][1:0] com_level,
	input wire logic [32:0][1:0] seg_level,
	// pixels lit so far
	output logic [3:0][32:0] lit = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	// only full-scale difference lights; middle levels leave it dark
	always @(posedge clk) begin
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 33; j++) begin
				if ({com_level[k], seg_level[j]} inside {4'hc, 4'h3}) begin
					lit[k][j] <= 1'b1;
				end
			end
		end
	end
endmodule // lcdsd_panel

// *** lcdsd_driver_tb.sv ***
// self-checking bench for the segment lcd driver
module lcdsd_driver_tb import lcdsd_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic halt = 1'b0;
	logic real_time_oscillator = 1'b0;
	logic watchdog_oscillator = 1'b0;
	lcdsd_cpu_req_t cpu_req = '0;
	lcdsd_option_t opt;
	lcdsd_cpu_req_t gp_req;
	logic [7:0] rd_data;
	logic [7:0] bank_select_pointer;
	logic rd_valid;
	logic [3:0][1:0] com_level;
	logic [32:0][1:0] seg_level;
	logic [3:0][32:0] lit;
	int miscompares = 0;
	int checks_done = 0;
	always #10 clk = ~clk;
	// slow sources: one rising edge every 10 and every 6 clocks
	always begin
		repeat (5) @(negedge clk);
		real_time_oscillator = ~real_time_oscillator;
	end
	always begin
		repeat (3) @(negedge clk);
		watchdog_oscillator = ~watchdog_oscillator;
	end
	lcdsd_driver i_dut (.clk(clk), .reset(reset), .cpu_req(cpu_req),
		.rd_data(rd_data), .rd_valid(rd_valid), .gp_req(gp_req),
		.bank_select_pointer(bank_select_pointer), .opt(opt), .halt(halt),
		.real_time_oscillator(real_time_oscillator),
		.watchdog_oscillator(watchdog_oscillator),
		.com_level(com_level), .seg_level(seg_level));
	lcdsd_panel i_panel (.clk(clk), .com_level(com_level),
		.seg_level(seg_level), .lit(lit));
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic acc(logic [7:0] a, logic [7:0] d, logic w, logic ind);
		@(negedge clk);
		cpu_req = '{a, d, w, !w, ind};
		@(negedge clk);
		cpu_req = '0;
	endtask
	task automatic rd(logic [7:0] a, logic ind, logic v, logic [7:0] d);
		acc(a, 8'h00, 1'b0, ind);
		chk("claim", 8'(rd_valid), 8'(v));
		chk("forward", 8'(gp_req.rd), 8'(!v));
		if (v) begin
			chk("data", rd_data, d);
		end
	endtask
	// counts one whole active slot of the first common
	task automatic slot_len(int d, int exp);
		int n;
		n = 0;
		opt.duty = lcdsd_duty_t'(d);
		opt.div_sel = 3'(d);
		while (com_level[0] == 2'h3 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		while (com_level[0] != 2'h3 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000) begin
			miscompares++;
			complete_run();
		end else begin
			n = 0;
			while (com_level[0] == 2'h3 && n < 300) begin
				@(negedge clk);
				n++;
			end
			chk("slot", 8'(n), 8'(exp));
		end
	endtask
	initial begin
		opt = '{LCDSD_DUTY_HALF, 1'b1, LCDSD_SRC_SYS_DIV4, 3'h0, 1'b0, 1'b0,
			8'h00};
		repeat (5) @(negedge clk);
		reset = 1'b0;
		chk("bank", bank_select_pointer, 8'h00);
		rd(8'h45, 1'b1, 1'b0, 8'h00);
		acc(8'h45, 8'h33, 1'b1, 1'b1);
		chk("fwd wr", 8'(gp_req.wr), 8'h01);
		chk("fwd data", gp_req.wdata, 8'h33);
		acc(8'h04, 8'h01, 1'b1, 1'b0);
		chk("bank not fwd", 8'(gp_req.wr), 8'h00);
		rd(8'h04, 1'b0, 1'b1, 8'h01);
		acc(8'h45, 8'h0f, 1'b1, 1'b1);
		chk("window not fwd", 8'(gp_req.wr), 8'h00);
		rd(8'h45, 1'b1, 1'b1, 8'h0f);
		rd(8'h45, 1'b0, 1'b0, 8'h00);
		acc(8'h60, 8'h5a, 1'b1, 1'b1);
		rd(8'h60, 1'b1, 1'b1, 8'h5a);
		rd(8'h61, 1'b1, 1'b0, 8'h00);
		acc(8'h46, 8'h00, 1'b1, 1'b1);
		acc(8'h40, 8'h01, 1'b1, 1'b1);
		acc(8'h41, 8'h00, 1'b1, 1'b1);
		acc(8'h48, 8'h01, 1'b1, 1'b1);
		$display("test access done");
		for (int d = 0; d < 3; d++) begin
			slot_len(d, 16 << d);
		end
		chk("lit c0 s5", 8'(lit[0][5]), 8'h01);
		chk("lit c3 s5", 8'(lit[3][5]), 8'h01);
		chk("lit c0 s6", 8'(lit[0][6]), 8'h00);
		// four source ticks per slot at the smallest divider
		opt.src = LCDSD_SRC_RTC;
		slot_len(0, 40);
		opt.src = LCDSD_SRC_WDT;
		slot_len(0, 24);
		$display("test scan done");
		opt.low_group_logic = 1'b1;
		opt.middle_group_logic = 8'h01;
		repeat (2) @(negedge clk);
		chk("seg0", 8'(seg_level[0]), 8'h03);
		chk("seg1", 8'(seg_level[1]), 8'h00);
		chk("seg8", 8'(seg_level[8]), 8'h03);
		halt = 1'b1;
		repeat (2) @(negedge clk);
		chk("com0 halt", 8'(com_level[0]), 8'h00);
		chk("seg0 halt", 8'(seg_level[0]), 8'h03);
		$display("test logic done");
		complete_run();
	end
endmodule // lcdsd_driver_tb
